// *** src/scs_channel_regs.v ***
`timescale 1ns/1ns
`include "scs_regs.vh"
module scs_channel_regs (
  input  wire        ref_clk_in,          // 100 MHz clock
  input  wire        sys_rst_in,          // async reset, high
  input  wire [7:0]  s_axi_awaddr_in,     // write address
  input  wire        s_axi_awvalid_in,    // write address valid
  output reg         s_axi_awready_out,   // write address ready
  input  wire [31:0] s_axi_wdata_in,      // write data
  input  wire [3:0]  s_axi_wstrb_in,      // byte enables
  input  wire        s_axi_wvalid_in,     // write data valid
  output reg         s_axi_wready_out,    // write data ready
  output reg  [1:0]  s_axi_bresp_out,     // write response
  output reg         s_axi_bvalid_out,    // write response valid
  input  wire        s_axi_bready_in,     // write response ready
  input  wire [7:0]  s_axi_araddr_in,     // read address
  input  wire        s_axi_arvalid_in,    // read address valid
  output reg         s_axi_arready_out,   // read address ready
  output reg  [31:0] s_axi_rdata_out,     // read data
  output reg  [1:0]  s_axi_rresp_out,     // read response
  output reg         s_axi_rvalid_out,    // read data valid
  input  wire        s_axi_rready_in,     // read data ready
  input  wire        cts_in,              // modem pin level
  input  wire        dsr_in,              // modem pin level
  input  wire        cd_in,               // modem pin level
  input  wire        ri_in,               // modem pin level
  input  wire        tx_frame_push_in,    // length entry pushed to tx length queue
  input  wire        tx_frame_end_in,     // frame on the line finished
  input  wire        tx_queue_empty_in,   // tx queue holds no bytes
  input  wire        tx_queue_ovf_in,     // write would pass tx queue size
  input  wire        rx_frame_start_in,   // receive frame begins
  input  wire        rx_abort_seq_in,     // abort sequence inside frame
  input  wire        rx_crc_valid_in,     // crc result strobe
  input  wire        rx_crc_fail_in,      // crc result, high on fail
  input  wire        rx_len_exceed_in,    // length check overrun
  input  wire        rx_frame_end_in,     // receive frame ended
  input  wire [16:0] rx_frame_bits_in,    // bits in ended frame
  input  wire [1:0]  rx_addr_bytes_in,    // enabled address bytes
  input  wire [1:0]  rx_crc_bytes_in,     // enabled crc bytes
  input  wire        rx_lost_in,          // data after unserviced overflow
  input  wire        rx_overflow_in,      // rx queue overflowed
  input  wire        rx_status_push_in,   // status word pushed to rx queue
  input  wire [15:0] rx_data_bytes_in,    // data bytes pushed for this frame
  input  wire        rx_frame_pop_in,     // rx length entry read out
  input  wire        dpll_in_use_in,      // rx clock recovered by dpll
  input  wire        dpll_lost_in,        // dpll lost lock
  input  wire        clock_mode5_in,      // clock mode 5 selected
  input  wire        timer_expired_in,    // timer expiry pulse
  output reg         timer_run_out,       // timer counting
  output reg         timer_clear_out,     // timer back to initial state
  output reg         timer_event_out,     // timer expiry event
  output reg         sync_search_out,     // drop sync, sync_search_cmd
  output reg         rx_reset_out,        // reset receiver, flush rx queue
  output reg         rx_block_out,        // receive disabled
  output reg         rx_abort_out,        // abort current rx frame
  output reg         rx_len_wr_out,       // rx length queue write
  output reg  [15:0] rx_len_data_out,     // rx length entry
  output reg         tx_send_out,         // start one frame with opening sequence
  output reg         tx_repeat_out,       // loop the frame
  output reg         tx_reset_out,        // abandon frame, idle, flush tx queue
  output reg         tx_pause_out         // hold transmit as on cts loss
);
  reg        aw_held_reg;
  reg [7:0]  awaddr_reg;
  reg        w_held_reg;
  reg [31:0] wdata_reg;
  reg [3:0]  wstrb_reg;
  reg [2:0]  busy_cnt_reg;
  reg        repeat_reg;
  reg        halt_pend_reg;
  reg        timed_reg;
  reg        tx_ovf_reg;
  reg        abort_reg;
  reg        crc_reg;
  reg        len_exc_reg;
  reg        invalid_reg;
  reg        lost_reg;
  reg        overflow_reg;
  reg        unlocked_reg;
  reg [31:0] rd_word;
  reg [1:0]  rd_resp;
  reg [31:0] status_word;

  wire [`SCS_TX_CNT_W-1:0] tx_count;
  wire [`SCS_RX_CNT_W-1:0] rx_count;
  wire                     tx_len_full;

  // widen byte strobes into a bit mask
  function [31:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // high when the frame is not whole bytes or shorter than data+address+crc
  function frame_bad;
    input [16:0] bits;
    input [1:0]  addr_b;
    input [1:0]  crc_b;
    reg   [16:0] min_bits;
    begin
      min_bits  = {9'h000, ({3'h0, addr_b} + {3'h0, crc_b} + 5'h01), 3'h0};
      frame_bad = (bits[2:0] != 3'h0) || (bits < min_bits);
    end
  endfunction

  wire        wr_fire    = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
  wire        wr_is_cmd  = (awaddr_reg == `SCS_OFS_COMMAND);
  wire        cmd_busy   = (busy_cnt_reg != 3'h0);
  // a command written while busy is dropped; software must poll the busy bit
  wire        cmd_accept = wr_fire && wr_is_cmd && !cmd_busy;
  wire [31:0] cmd_bits   = cmd_accept ? (wdata_reg & lane_mask(wstrb_reg)) : 32'h00000000;
  wire        rd_fire    = s_axi_arvalid_in && s_axi_arready_out;
  wire        status_rd  = rd_fire && (s_axi_araddr_in == `SCS_OFS_STATUS);
  wire        c_tstart   = cmd_bits[`SCS_CMD_TIMER_START];
  wire        c_tstop    = cmd_bits[`SCS_CMD_TIMER_STOP];
  wire        c_send     = cmd_bits[`SCS_CMD_SEND_FRAME];
  wire        c_rep      = cmd_bits[`SCS_CMD_REPEAT_SEND];
  wire        c_halt     = cmd_bits[`SCS_CMD_REPEAT_HALT];
  wire        c_txrst    = cmd_bits[`SCS_CMD_TX_RESET];
  wire        c_timed    = cmd_bits[`SCS_CMD_TIMED_SEND];
  wire        c_rxrst    = cmd_bits[`SCS_CMD_RX_RESET];
  wire        timer_fire = timer_expired_in && timer_run_out;

  scs_frame_counter #(
    .W   (`SCS_TX_CNT_W),
    .MAX (`SCS_TX_CNT_MAX)
  ) u_tx_count (
    .clk_in    (ref_clk_in),
    .rst_in    (sys_rst_in),
    .clear_in  (c_txrst),
    .inc_in    (tx_frame_push_in),
    .dec_in    (tx_frame_end_in),
    .count_out (tx_count),
    .full_out  (tx_len_full)
  );

  scs_frame_counter #(
    .W   (`SCS_RX_CNT_W),
    .MAX (`SCS_RX_CNT_MAX)
  ) u_rx_count (
    .clk_in    (ref_clk_in),
    .rst_in    (sys_rst_in),
    .clear_in  (c_rxrst),
    .inc_in    (rx_status_push_in),
    .dec_in    (rx_frame_pop_in),
    .count_out (rx_count),
    .full_out  ()
  );

  always @* begin
    status_word                    = 32'h00000000;
    status_word[`SCS_ST_CTS]       = cts_in;
    status_word[`SCS_ST_DSR]       = dsr_in;
    status_word[`SCS_ST_CD]        = cd_in;
    status_word[`SCS_ST_RI]        = ri_in;
    status_word[`SCS_ST_ABORT]     = abort_reg;
    status_word[`SCS_ST_CRC]       = crc_reg;
    status_word[`SCS_ST_LEN_EXC]   = len_exc_reg;
    status_word[`SCS_ST_INVALID]   = invalid_reg;
    status_word[`SCS_ST_LOST]      = lost_reg;
    status_word[`SCS_ST_OVERFLOW]  = overflow_reg;
    status_word[`SCS_ST_TX_EMPTY]  = tx_queue_empty_in;
    status_word[`SCS_ST_LEN_FULL]  = tx_len_full;
    status_word[`SCS_ST_CMD_BUSY]  = cmd_busy;
    status_word[`SCS_ST_UNLOCKED]  = unlocked_reg;
    status_word[`SCS_ST_REPEAT]    = repeat_reg;
    status_word[`SCS_ST_TIMED]     = timed_reg;
    status_word[`SCS_ST_TX_OVF]    = tx_ovf_reg;
  end

  always @* begin
    rd_resp = `SCS_RESP_OKAY;
    case (s_axi_araddr_in)
      `SCS_OFS_FRAME_CNT: rd_word = {7'h00, tx_count, 6'h00, rx_count};
      `SCS_OFS_COMMAND:   rd_word = 32'h00000000;
      `SCS_OFS_STATUS:    rd_word = status_word;
      default: begin
        rd_word = 32'h00000000;
        rd_resp = `SCS_RESP_SLVERR;
      end
    endcase
  end

  // write channel: address and data may arrive in either order
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `SCS_RESP_OKAY;
      aw_held_reg       <= 1'b0;
      w_held_reg        <= 1'b0;
      awaddr_reg        <= 8'h00;
      wdata_reg         <= 32'h00000000;
      wstrb_reg         <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg       <= 1'b1;
        awaddr_reg        <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg       <= 1'b1;
        wdata_reg        <= s_axi_wdata_in;
        wstrb_reg        <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg      <= 1'b0;
        w_held_reg       <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        if (awaddr_reg == `SCS_OFS_FRAME_CNT || awaddr_reg == `SCS_OFS_STATUS || wr_is_cmd)
          s_axi_bresp_out <= `SCS_RESP_OKAY;
        else
          s_axi_bresp_out <= `SCS_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `SCS_RESP_OKAY;
    end else begin
      if (rd_fire) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= rd_word;
        s_axi_rresp_out   <= rd_resp;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // command execution, timer and transmit control
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      busy_cnt_reg    <= 3'h0;
      timer_run_out   <= 1'b0;
      timer_clear_out <= 1'b0;
      timer_event_out <= 1'b0;
      sync_search_out <= 1'b0;
      rx_reset_out    <= 1'b0;
      tx_send_out     <= 1'b0;
      tx_reset_out    <= 1'b0;
      tx_repeat_out   <= 1'b0;
      repeat_reg      <= 1'b0;
      halt_pend_reg   <= 1'b0;
      timed_reg       <= 1'b0;
    end else begin
      if (cmd_accept)
        busy_cnt_reg <= `SCS_CMD_BUSY_CYCLES;
      else if (cmd_busy)
        busy_cnt_reg <= busy_cnt_reg - 3'h1;
      // pulses last one cycle so nothing is held in the command word
      timer_clear_out <= c_tstop;
      sync_search_out <= cmd_bits[`SCS_CMD_SYNC_SEARCH];
      rx_reset_out    <= c_rxrst;
      tx_reset_out    <= c_txrst;
      timer_event_out <= timer_fire && !c_tstop;
      if (c_tstop)
        timer_run_out <= 1'b0;
      else if (c_tstart)
        timer_run_out <= 1'b1;
      // immediate send, or one frame per expiry while timed mode is armed
      tx_send_out <= !c_txrst && ((((c_send || c_rep) && !c_timed)
                     || (timed_reg && timer_fire)));
      if (c_txrst) begin
        repeat_reg    <= 1'b0;
        halt_pend_reg <= 1'b0;
        timed_reg     <= 1'b0;
      end else begin
        if (c_rep)
          repeat_reg <= 1'b1;
        else if (halt_pend_reg && tx_frame_end_in)
          repeat_reg <= 1'b0;
        if (c_halt && (repeat_reg || c_rep))
          halt_pend_reg <= 1'b1;
        else if (tx_frame_end_in)
          halt_pend_reg <= 1'b0;
        if (c_timed && (c_send || c_rep))
          timed_reg <= 1'b1;
        else if (tx_frame_end_in && (!repeat_reg || halt_pend_reg))
          timed_reg <= 1'b0;
      end
      tx_repeat_out <= repeat_reg && !timed_reg && !halt_pend_reg && !c_halt && !c_txrst;
    end
  end

  // receive status flags: a set in the same cycle as the push survives
  always @(posedge ref_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_ovf_reg      <= 1'b0;
      abort_reg       <= 1'b0;
      crc_reg         <= 1'b0;
      len_exc_reg     <= 1'b0;
      invalid_reg     <= 1'b0;
      lost_reg        <= 1'b0;
      overflow_reg    <= 1'b0;
      unlocked_reg    <= 1'b0;
      rx_block_out    <= 1'b0;
      tx_pause_out    <= 1'b0;
      rx_abort_out    <= 1'b0;
      rx_len_wr_out   <= 1'b0;
      rx_len_data_out <= 16'h0000;
    end else begin
      if (tx_queue_ovf_in)
        tx_ovf_reg <= 1'b1;
      else if (status_rd)
        tx_ovf_reg <= 1'b0;
      if (rx_abort_seq_in)
        abort_reg <= 1'b1;
      else if (rx_status_push_in)
        abort_reg <= 1'b0;
      if (rx_crc_valid_in)
        crc_reg <= rx_crc_fail_in;
      else if (rx_status_push_in)
        crc_reg <= 1'b0;
      if (rx_len_exceed_in)
        len_exc_reg <= 1'b1;
      else if (rx_status_push_in)
        len_exc_reg <= 1'b0;
      if (rx_frame_end_in && frame_bad(rx_frame_bits_in, rx_addr_bytes_in, rx_crc_bytes_in))
        invalid_reg <= 1'b1;
      else if (rx_status_push_in)
        invalid_reg <= 1'b0;
      if (rx_lost_in)
        lost_reg <= 1'b1;
      else if (rx_status_push_in)
        lost_reg <= 1'b0;
      if (rx_overflow_in)
        overflow_reg <= 1'b1;
      else if (rx_status_push_in)
        overflow_reg <= 1'b0;
      if (dpll_in_use_in && dpll_lost_in)
        unlocked_reg <= 1'b1;
      else if (rx_frame_start_in || !dpll_in_use_in)
        unlocked_reg <= 1'b0;
      rx_block_out  <= unlocked_reg;
      tx_pause_out  <= unlocked_reg && clock_mode5_in;
      rx_abort_out  <= rx_len_exceed_in;
      // length entry counts data plus the status word just pushed
      rx_len_wr_out <= rx_status_push_in;
      if (rx_status_push_in)
        rx_len_data_out <= rx_data_bytes_in + `SCS_STATUS_BYTES;
    end
  end
endmodule

// *** inc/scs_regs.vh ***
// Operation
// - transmit frame count reads as 9 bits, 0 to 256, queued length entries.
// - receive frame count reads as 10 bits, 0 to 512, queued length entries.
// - each command bit acts when written one and never reads back stored.
// - timer start runs the timer with expiry events; stop halts and resets it.
// - sync search command drops sync at once and restarts the search.
// - receiver reset empties receive queue and restarts receiver immediately.
// - software loads the frame first; send command starts it with opening sequence.
// - repeat send loops the frame; repeat halt stops after the current frame.
// - transmitter reset abandons frame, idles, empties queue, accepts new data.
// - timed send with send or repeat sends one frame per timer expiry.
// - bit 24 clears on read, 13..8 on status push, live bits never latch.
// - lowest four status bits mirror live CTS, DSR, CD and RI pins.
// - abort flag sets when an abort sequence arrives during a frame.
// - frame check flag is one on CRC failure and zero on pass.
// - length check overrun aborts the frame and sets length exceeded flag.
// - frames not byte multiple or below minimum size flagged invalid, still queued.
// - frame lost flag sets when unserviced overflow was followed by more data.
// - receive overflow flag sets when the message overflows the receive queue.
// - live empty flag for transmit queue; live full flag at 256 frames.
// - command in progress flag high during execution; software must wait.
// - clock recovery unlock sets flag, blocks receive, pauses transmit in mode 5.
// - live repeat and timed flags; transmit overflow flag cleared on status read.
// - receive length entry written after frame: data bytes plus status word.
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

`define SCS_ADDR_W          8
`define SCS_OFS_FRAME_CNT   8'h10
`define SCS_OFS_COMMAND     8'h14
`define SCS_OFS_STATUS      8'h18

`define SCS_TX_CNT_W        9
`define SCS_RX_CNT_W        10
`define SCS_TX_CNT_MAX      9'h100
`define SCS_RX_CNT_MAX      10'h200
`define SCS_TX_CNT_LSB      16

`define SCS_CMD_TIMER_START 0
`define SCS_CMD_TIMER_STOP  1
`define SCS_CMD_SYNC_SEARCH 16
`define SCS_CMD_RX_RESET    17
`define SCS_CMD_SEND_FRAME  24
`define SCS_CMD_REPEAT_SEND 25
`define SCS_CMD_REPEAT_HALT 26
`define SCS_CMD_TX_RESET    27
`define SCS_CMD_TIMED_SEND  28

`define SCS_ST_CTS          0
`define SCS_ST_DSR          1
`define SCS_ST_CD           2
`define SCS_ST_RI           3
`define SCS_ST_ABORT        8
`define SCS_ST_CRC          9
`define SCS_ST_LEN_EXC      10
`define SCS_ST_INVALID      11
`define SCS_ST_LOST         12
`define SCS_ST_OVERFLOW     13
`define SCS_ST_TX_EMPTY     16
`define SCS_ST_LEN_FULL     17
`define SCS_ST_CMD_BUSY     18
`define SCS_ST_UNLOCKED     19
`define SCS_ST_REPEAT       20
`define SCS_ST_TIMED        21
`define SCS_ST_TX_OVF       24

`define SCS_CMD_BUSY_CYCLES 3'h4
`define SCS_STATUS_BYTES    16'h0004
`define SCS_RESP_OKAY       2'h0
`define SCS_RESP_SLVERR     2'h2

`endif

// *** src/scs_frame_counter.v ***
`timescale 1ns/1ns
module scs_frame_counter #(
  parameter W   = 9,
  parameter MAX = 256
) (
  input  wire         clk_in,    // clock
  input  wire         rst_in,    // async reset, high
  input  wire         clear_in,  // empty the count
  input  wire         inc_in,    // one entry added
  input  wire         dec_in,    // one entry removed
  output reg  [W-1:0] count_out, // entries held
  output reg          full_out   // count at max
);
  localparam [W-1:0] MAX_W = MAX;
  localparam [W-1:0] ONE_W = 1;
  reg [W-1:0] count_next;

  always @* begin
    count_next = count_out;
    if (clear_in)
      count_next = {W{1'b0}};
    else if (inc_in && !dec_in && count_out != MAX_W)
      count_next = count_out + ONE_W;
    else if (dec_in && !inc_in && count_out != {W{1'b0}})
      count_next = count_out - ONE_W;
  end

  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_out <= {W{1'b0}};
      full_out  <= 1'b0;
    end else begin
      count_out <= count_next;
      full_out  <= (count_next == MAX_W);
    end
  end
endmodule

// *** tb/scs_line_model.sv ***
`timescale 1ns/1ns
// stands for the serial line side: a frame takes FRAME_CYC+1 cycles on the wire
module scs_line_model #(
  parameter FRAME_CYC = 6
) (
  input  wire clk_in,        // clock
  input  wire rst_in,        // async reset, high
  input  wire send_in,       // start one frame
  input  wire repeat_in,     // loop the frame
  input  wire reset_in,      // abandon frame
  output reg  frame_end_out  // frame finished on the line
);
  reg [3:0] cnt_reg;
  reg       busy_reg;
  always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      frame_end_out <= 1'b0;
    end else begin
      frame_end_out <= 1'b0;
      if (reset_in) begin
        busy_reg <= 1'b0;
      end else if (send_in) begin
        busy_reg <= 1'b1;
        cnt_reg <= 4'h0;
      end else if (busy_reg) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == FRAME_CYC) begin
          frame_end_out <= 1'b1;
          cnt_reg <= 4'h0;
          busy_reg <= repeat_in;
        end
      end
    end
  end
endmodule

// *** tb/scs_channel_regs_asserts.sv ***
`timescale 1ns/1ns
module scs_channel_regs_chk (
  input wire        ref_clk_in, sys_rst_in, s_axi_bvalid_out, s_axi_bready_in, s_axi_rvalid_out,
  input wire        s_axi_rready_in, rx_status_push_in, rx_len_wr_out, rx_len_exceed_in, rx_abort_out,
  input wire        tx_reset_out, timer_event_out, timer_expired_in, tx_pause_out, rx_block_out,
  input wire        clock_mode5_in, dpll_in_use_in, dpll_lost_in, rx_frame_start_in,
  input wire [1:0]  s_axi_bresp_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [15:0] rx_data_bytes_in, rx_len_data_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped early");
  AST_LEN_WR: assert property (rx_status_push_in |=> rx_len_wr_out && rx_len_data_out == $past(rx_data_bytes_in) + 16'h0004)
    else $error("rx length entry wrong");
  AST_LEN_ABORT: assert property (rx_len_exceed_in |=> rx_abort_out)
    else $error("length overrun did not abort");
  AST_ONE_SHOT: assert property (tx_reset_out |=> !tx_reset_out)
    else $error("command pulse held");
  AST_TIMER_EV: assert property (timer_event_out |-> $past(timer_expired_in))
    else $error("timer event without expiry");
  AST_PAUSE: assert property (tx_pause_out |-> rx_block_out && $past(clock_mode5_in))
    else $error("transmit pause outside mode 5 unlock");
  AST_UNLOCK: assert property (dpll_in_use_in && dpll_lost_in ##1 dpll_in_use_in && !rx_frame_start_in |=> rx_block_out)
    else $error("receive not blocked on unlock");
endmodule
bind scs_channel_regs scs_channel_regs_chk chk (.ref_clk_in, .sys_rst_in, .s_axi_bvalid_out, .s_axi_bready_in,
  .s_axi_rvalid_out, .s_axi_rready_in, .rx_status_push_in, .rx_len_wr_out, .rx_len_exceed_in, .rx_abort_out,
  .tx_reset_out, .timer_event_out, .timer_expired_in, .tx_pause_out, .rx_block_out, .clock_mode5_in,
  .dpll_in_use_in, .dpll_lost_in, .rx_frame_start_in, .s_axi_bresp_out, .s_axi_rdata_out, .rx_data_bytes_in,
  .rx_len_data_out);

// *** tb/tb.sv ***
`timescale 1ns/1ns
module tb;
  reg ref_clk_in = 0, sys_rst_in = 1, s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
  reg s_axi_arvalid_in = 0, s_axi_rready_in = 0, cts_in = 0, dsr_in = 0, cd_in = 0, ri_in = 0, clr = 0;
  reg tx_queue_empty_in = 0, rx_crc_fail_in = 1, dpll_in_use_in = 0, clock_mode5_in = 0;
  reg [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  reg [31:0] s_axi_wdata_in = 32'h0, rd;
  reg [16:0] rx_frame_bits_in = 17'h00018;
  reg [15:0] rx_data_bytes_in = 16'h0010;
  reg [12:0] ev = 13'h0;
  reg [5:0] seen = 6'h0;
  wire [3:0] s_axi_wstrb_in = 4'hF;
  wire [1:0] rx_addr_bytes_in = 2'h1, rx_crc_bytes_in = 2'h2, s_axi_bresp_out, s_axi_rresp_out;
  wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, rx_len_wr_out;
  wire timer_run_out, timer_clear_out, timer_event_out, sync_search_out, rx_reset_out, rx_block_out, rx_abort_out;
  wire tx_send_out, tx_repeat_out, tx_reset_out, tx_pause_out, tx_frame_end_in, tx_frame_push_in, tx_queue_ovf_in;
  wire rx_frame_start_in, rx_abort_seq_in, rx_crc_valid_in, rx_len_exceed_in, rx_frame_end_in, rx_lost_in;
  wire rx_overflow_in, rx_status_push_in, rx_frame_pop_in, dpll_lost_in, timer_expired_in;
  wire [31:0] s_axi_rdata_out;
  wire [15:0] rx_len_data_out;
  integer mismatches = 0, samples_checked = 0, cycles = 0, i;
  assign {timer_expired_in, dpll_lost_in, rx_frame_pop_in, rx_status_push_in, rx_overflow_in, rx_lost_in,
    rx_frame_end_in, rx_len_exceed_in, rx_crc_valid_in, rx_abort_seq_in, rx_frame_start_in, tx_queue_ovf_in,
    tx_frame_push_in} = ev;
  scs_channel_regs uut (.ref_clk_in, .sys_rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
    .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
    .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
    .s_axi_rvalid_out, .s_axi_rready_in, .cts_in, .dsr_in, .cd_in, .ri_in, .tx_frame_push_in, .tx_frame_end_in,
    .tx_queue_empty_in, .tx_queue_ovf_in, .rx_frame_start_in, .rx_abort_seq_in, .rx_crc_valid_in, .rx_crc_fail_in,
    .rx_len_exceed_in, .rx_frame_end_in, .rx_frame_bits_in, .rx_addr_bytes_in, .rx_crc_bytes_in, .rx_lost_in,
    .rx_overflow_in, .rx_status_push_in, .rx_data_bytes_in, .rx_frame_pop_in, .dpll_in_use_in, .dpll_lost_in,
    .clock_mode5_in, .timer_expired_in, .timer_run_out, .timer_clear_out, .timer_event_out, .sync_search_out,
    .rx_reset_out, .rx_block_out, .rx_abort_out, .rx_len_wr_out, .rx_len_data_out, .tx_send_out, .tx_repeat_out,
    .tx_reset_out, .tx_pause_out);
  scs_line_model line (.clk_in(ref_clk_in), .rst_in(sys_rst_in), .send_in(tx_send_out), .repeat_in(tx_repeat_out),
    .reset_in(tx_reset_out), .frame_end_out(tx_frame_end_in));
  initial forever #5 ref_clk_in = ~ref_clk_in;
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    seen <= clr ? 6'h00 : seen | {timer_event_out, tx_reset_out, tx_send_out, rx_reset_out, sync_search_out,
      timer_clear_out};
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      print_verdict;
    end
  end
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    @(posedge ref_clk_in);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1;
    s_axi_wvalid_in <= 1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 0;
      if (s_axi_bvalid_out && !s_axi_bready_in) s_axi_bready_in <= 1;
    end while ({s_axi_bready_in, s_axi_bvalid_out} !== 2'h3);
    s_axi_bready_in <= 0;
  endtask
  task rdr(input [7:0] a);
    @(posedge ref_clk_in);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1;
    do begin
      @(posedge ref_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 0;
      if (s_axi_rvalid_out && !s_axi_rready_in) s_axi_rready_in <= 1;
    end while ({s_axi_rready_in, s_axi_rvalid_out} !== 2'h3);
    rd = s_axi_rresp_out == 2'h2 ? 32'hEEEEEEEE : s_axi_rdata_out;
    s_axi_rready_in <= 0;
  endtask
  task fire(input integer n);
    @(posedge ref_clk_in);
    ev <= 13'h0001 << n;
    @(posedge ref_clk_in);
    ev <= 13'h0000;
  endtask
  // busy lasts a few cycles, so each command waits it out before the next
  task cmd(input [31:0] d, input [5:0] e);
    @(posedge ref_clk_in);
    clr <= 1;
    @(posedge ref_clk_in);
    clr <= 0;
    wr(8'h14, d);
    rdr(8'h18);
    chk("command busy", rd[18], 1);
    repeat (10) @(posedge ref_clk_in);
    chk("command pulses", seen, e);
  endtask
  task print_verdict;
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 0;
    rdr(8'h10);
    chk("counts at reset", rd, 32'h0);
    for (i = 0; i < 3; i++) fire(0);
    for (i = 0; i < 2; i++) fire(9);
    rdr(8'h10);
    chk("frame counts", rd, 32'h00030002);
    for (i = 3; i < 9; i++) fire(i);
    rdr(8'h18);
    chk("rx frame flags", rd[13:8], 6'h3F);
    rx_crc_fail_in <= 0;
    fire(4);
    rdr(8'h18);
    chk("crc pass", rd[9], 0);
    fire(9);
    rdr(8'h18);
    chk("flags after push", rd[13:8], 6'h00);
    fire(1);
    rdr(8'h18);
    chk("tx overflow", rd[24], 1);
    rdr(8'h18);
    chk("tx overflow read clear", rd[24], 0);
    {ri_in, cd_in, dsr_in, cts_in} <= 4'hA;
    tx_queue_empty_in <= 1;
    for (i = 0; i < 254; i++) fire(0);
    rdr(8'h18);
    chk("pins", rd[3:0], 4'hA);
    chk("tx empty and full", rd[17:16], 2'h3);
    rdr(8'h10);
    chk("tx count saturated", rd[24:16], 9'h100);
    rdr(8'h40);
    chk("unmapped read", rd, 32'hEEEEEEEE);
    wr(8'h40, 32'h0);
    chk("unmapped write", s_axi_bresp_out, 2'h2);
    for (i = 0; i < 4; i++) cmd(32'h1 << (i < 2 ? 16 + i : 18 + 3 * i), 6'h02 << i);
    rdr(8'h10);
    chk("counts after resets", rd, 32'h0);
    cmd(32'h02000000, 6'h08);
    rdr(8'h18);
    chk("repeat active", {rd[20], tx_repeat_out}, 2'h3);
    cmd(32'h04000000, 6'h00);
    repeat (30) @(posedge ref_clk_in);
    rdr(8'h18);
    chk("repeat stopped", {rd[20], tx_repeat_out}, 2'h0);
    cmd(32'h00000001, 6'h00);
    chk("timer running", timer_run_out, 1);
    cmd(32'h11000000, 6'h00);
    rdr(8'h18);
    chk("timed active", rd[21], 1);
    fire(12);
    repeat (3) @(posedge ref_clk_in);
    chk("timed send", seen, 6'h28);
    cmd(32'h00000002, 6'h01);
    chk("timer stopped", timer_run_out, 0);
    dpll_in_use_in <= 1;
    clock_mode5_in <= 1;
    fire(11);
    rdr(8'h18);
    chk("unlocked", rd[19], 1);
    chk("rx block and tx pause", {rx_block_out, tx_pause_out}, 2'h3);
    fire(2);
    rdr(8'h18);
    chk("unlock cleared by frame", rd[19], 0);
    print_verdict;
  end
endmodule
